/* File: common/sipo_pkg.sv */
// Constants, carrier types and helpers shared by the serial-in,
// parallel-out latch.
// Assumes one sys clock domain and one shift (link) clock domain.
package sipo_pkg;

  // ----------------------------------------------------------------
  // Widths, reset values and sizes
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 8;
  localparam logic [WORD_W-1:0] SHIFT_RESET = 8'h00;
  localparam logic [WORD_W-1:0] STORE_RESET = 8'h00;
  localparam logic [WORD_W-1:0] MIRROR_RESET = 8'h00;
  localparam int unsigned FIFO_DEPTH = 2;
  localparam logic SYNC_RESET = 1'b0;
  localparam logic OE_N_RESET = 1'b1;
  localparam logic CLR_N_RESET = 1'b1;
  localparam logic PTR_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WORD_W-1:0] bits;
  } word_s;

  typedef enum logic [2:0] {
    FIFO_EMPTY = 3'b001,
    FIFO_ONE   = 3'b010,
    FIFO_TWO   = 3'b100
  } fifo_e;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Rising edge of a synchronised level
  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : rise

  // Any change of a synchronised toggle
  function automatic logic flipped(input logic now, input logic prev);
    return now ^ prev;
  endfunction : flipped

endpackage : sipo_pkg

/* File: src/sipo_latch.sv */
// Eight-bit serial-in shift register feeding a storage register with
// tri-state parallel outputs, plus a stream copy of each word stored while the stream buffer has room.
// Assumes SHIFT_CLOCK comes from the host and may stop between frames;
// the storage clock and output enable are pins sampled on CLK_SYS.
`timescale 1ns/10ps

// Behaviour
// (R1) Eight shift stages feed eight storage flops
// (R2) Shift edge moves stages, first takes input
// (R3) Storage edge copies shift bits to storage
// (R4) Shift and storage advance on separate clocks
// (R5) Tied clocks: storage gets pre-edge contents
// (R6) Clear low zeroes stages and serial output
// (R7) Enable high floats outputs, low drives storage
// (R8) Last stage always driven on serial output
// (R9) Clear leaves storage register untouched
// (R10) Output enable changes drive only, not contents
module sipo_latch (
  input wire logic CLK_SYS, // System clock, 250 MHz
  input wire logic RST, // Async reset, active high
  input wire logic SHIFT_CLOCK, // Shift clock from host, rising edge
  input wire logic SERIAL_IN, // Serial data, sampled on shift clock
  input wire logic SHIFT_CLEAR_N, // Clear of shift stages, active low
  input wire logic STORAGE_CLOCK, // Storage clock pin, rising edge
  input wire logic OUT_ENABLE_N, // Parallel output enable, active low
  output logic [sipo_pkg::WORD_W-1:0] PAR_OUT, // Parallel output levels
  output logic [sipo_pkg::WORD_W-1:0] PAR_OE_N, // Low while PAR_OUT drives
  output logic SERIAL_OUT, // Cascade output, last stage
  output logic LOAD_READY, // Stream buffer can take a word
  output logic WORD_VALID, // Stream word available
  input wire logic WORD_READY, // Consumer takes stream word
  output sipo_pkg::word_s WORD_DATA // Stream word, each value stored while the buffer is not full
);

  // ----------------------------------------------------------------
  // Shift clock domain
  // ----------------------------------------------------------------
  logic link_rst;
  logic [sipo_pkg::WORD_W-1:0] shift;
  logic [sipo_pkg::WORD_W-1:0] next_shift;
  logic shift_tog;
  logic next_shift_tog;

  // Clear overrides the shift clock at once, so it joins the reset
  assign link_rst = RST | ~SHIFT_CLEAR_N; // R6

  // Next shift contents and event toggle
  always_comb
  begin
    next_shift = {shift[sipo_pkg::WORD_W-2:0], SERIAL_IN}; // R2
    next_shift_tog = ~shift_tog;
  end

  // Shift stages, cleared directly by the clear pin
  always_ff @(posedge SHIFT_CLOCK or posedge link_rst)
  begin
    if (link_rst)
    begin
      shift <= sipo_pkg::SHIFT_RESET; // R6
    end
    else
    begin
      shift <= next_shift; // R1 R2 R4
    end
  end

  // Toggle marks each shift edge; held outside the clear so no event is faked
  always_ff @(posedge SHIFT_CLOCK or posedge RST)
  begin
    if (RST)
    begin
      shift_tog <= sipo_pkg::SYNC_RESET;
    end
    else
    begin
      shift_tog <= next_shift_tog;
    end
  end

  // Cascade output straight from the last stage, never floated
  assign SERIAL_OUT = shift[sipo_pkg::WORD_W-1]; // R8 R6

  // ----------------------------------------------------------------
  // Pin and crossing synchronisers (sys domain)
  // ----------------------------------------------------------------
  logic tog_meta, tog_sync, tog_prev;
  logic clr_meta, clr_sync;
  logic stc_meta, stc_sync, stc_prev;
  logic oe_meta, oe_sync;
  logic next_tog_prev, next_stc_prev;

  // Edge memories for the detectors
  always_comb
  begin
    next_tog_prev = tog_sync;
    next_stc_prev = stc_sync;
  end

  // Two flops per crossing level; first stages feed only the second
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      tog_meta <= sipo_pkg::SYNC_RESET;
      tog_sync <= sipo_pkg::SYNC_RESET;
      tog_prev <= sipo_pkg::SYNC_RESET;
      clr_meta <= sipo_pkg::CLR_N_RESET;
      clr_sync <= sipo_pkg::CLR_N_RESET;
      stc_meta <= sipo_pkg::SYNC_RESET;
      stc_sync <= sipo_pkg::SYNC_RESET;
      stc_prev <= sipo_pkg::SYNC_RESET;
      oe_meta <= sipo_pkg::OE_N_RESET;
      oe_sync <= sipo_pkg::OE_N_RESET;
    end
    else
    begin
      tog_meta <= shift_tog;
      tog_sync <= tog_meta;
      tog_prev <= next_tog_prev;
      clr_meta <= SHIFT_CLEAR_N;
      clr_sync <= clr_meta;
      stc_meta <= STORAGE_CLOCK;
      stc_sync <= stc_meta;
      stc_prev <= next_stc_prev;
      oe_meta <= OUT_ENABLE_N;
      oe_sync <= oe_meta;
    end
  end

  // ----------------------------------------------------------------
  // Mirror and storage register
  // ----------------------------------------------------------------
  logic arrive, load;
  logic [sipo_pkg::WORD_W-1:0] mirror, next_mirror;
  logic [sipo_pkg::WORD_W-1:0] store, next_store;

  assign arrive = sipo_pkg::flipped(tog_sync, tog_prev);
  assign load = sipo_pkg::rise(stc_sync, stc_prev);

  // The shift word is read after its toggle has crossed, so it has been
  // stable for two sys cycles. Under clear the stages already read zero, so
  // the mirror follows them; a shift edge soon after release is not lost.
  // Both pins see equal latency, so tied clocks load the mirror's old value.
  always_comb
  begin
    next_mirror = mirror;
    next_store = store;
    if (!clr_sync || arrive)
    begin
      next_mirror = shift; // R6
    end
    if (load)
    begin
      next_store = mirror; // R3 R5 R9
    end
  end

  // Mirror and storage flops; nothing but a storage edge changes the storage
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      mirror <= sipo_pkg::MIRROR_RESET;
      store <= sipo_pkg::STORE_RESET;
    end
    else
    begin
      mirror <= next_mirror;
      store <= next_store; // R1 R4
    end
  end

  // Enable steers drive only; storage is never gated by it
  assign PAR_OUT = store; // R7 R10
  assign PAR_OE_N = {sipo_pkg::WORD_W{oe_sync}}; // R7

  // ----------------------------------------------------------------
  // Two-entry stream buffer of stored words
  // ----------------------------------------------------------------
  sipo_pkg::fifo_e fill, next_fill;
  sipo_pkg::word_s mem [sipo_pkg::FIFO_DEPTH];
  sipo_pkg::word_s next_mem [sipo_pkg::FIFO_DEPTH];
  logic wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic push, pop;

  // A full buffer drops the stream copy only; the storage load still lands
  assign LOAD_READY = (fill != sipo_pkg::FIFO_TWO);
  assign WORD_VALID = (fill != sipo_pkg::FIFO_EMPTY);
  assign push = load & LOAD_READY;
  assign pop = WORD_VALID & WORD_READY;

  // Occupancy and pointers
  always_comb
  begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill = fill;
    if (push)
    begin
      next_mem[wr_ptr].bits = mirror;
      next_wr_ptr = ~wr_ptr;
    end
    if (pop)
    begin
      next_rd_ptr = ~rd_ptr;
    end
    unique case (fill)
      sipo_pkg::FIFO_EMPTY:
      begin
        if (push)
        begin
          next_fill = sipo_pkg::FIFO_ONE;
        end
      end
      sipo_pkg::FIFO_ONE:
      begin
        if (push && !pop)
        begin
          next_fill = sipo_pkg::FIFO_TWO;
        end
        else if (pop && !push)
        begin
          next_fill = sipo_pkg::FIFO_EMPTY;
        end
      end
      sipo_pkg::FIFO_TWO:
      begin
        if (pop)
        begin
          next_fill = sipo_pkg::FIFO_ONE;
        end
      end
      default:
      begin
        next_fill = sipo_pkg::FIFO_EMPTY;
      end
    endcase
  end

  // Buffer flops
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      mem[0] <= '{bits: sipo_pkg::STORE_RESET};
      mem[1] <= '{bits: sipo_pkg::STORE_RESET};
      wr_ptr <= sipo_pkg::PTR_RESET;
      rd_ptr <= sipo_pkg::PTR_RESET;
      fill <= sipo_pkg::FIFO_EMPTY;
    end
    else
    begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

  assign WORD_DATA = mem[rd_ptr];

endmodule : sipo_latch

/* File: tb/host_link.sv */
// Host side of the link: shift clock, data and clear.
// Assumes tasks start on a CLK_SYS falling edge.
`timescale 1ns/10ps
module host_link (
  output logic SHIFT_CLOCK, // Stands low between frames
  output logic SERIAL_IN, // Data
  output logic SHIFT_CLEAR_N // Clear
);
  // --------
  // Frames
  // --------
  initial
  begin
    SHIFT_CLOCK = 1'b0;
    SERIAL_IN = 1'b0;
    SHIFT_CLEAR_N = 1'b1;
  end
  // Top bit first; 64 ns period, rises kept off CLK_SYS edges
  task automatic send(input logic [7:0] w);
    for (int i = 7; i >= 0; i--)
    begin
      SERIAL_IN = w[i];
      #16.3 SHIFT_CLOCK = 1'b1;
      #32 SHIFT_CLOCK = 1'b0;
      #15.7;
    end
    SERIAL_IN = ~w[0]; // Stale data inverted
  endtask : send
  task automatic clear();
    SHIFT_CLEAR_N = 1'b0;
    #20 SHIFT_CLEAR_N = 1'b1;
  endtask : clear
endmodule : host_link

/* File: tb/sipo_latch_monitor.sv */
// Checker on the latch ports.
// Assumes host pins move away from CLK_SYS edges.
`timescale 1ns/10ps
module sipo_latch_monitor (
  input wire logic CLK_SYS, // Clock
  input wire logic RST, // Reset
  input wire logic SHIFT_CLOCK, // Shift clock
  input wire logic SERIAL_IN, // Data
  input wire logic SHIFT_CLEAR_N, // Clear
  input wire logic STORAGE_CLOCK, // Store
  input wire logic OUT_ENABLE_N, // Enable
  input wire logic [7:0] PAR_OUT, // Outputs
  input wire logic [7:0] PAR_OE_N, // Drive
  input wire logic SERIAL_OUT, // Cascade
  input wire logic LOAD_READY, // Room
  input wire logic WORD_VALID, // Valid
  input wire logic WORD_READY, // Ready
  input wire sipo_pkg::word_s WORD_DATA // Head
);
  // --------
  // Relations
  // --------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  chk_oe_drive: assert property (!OUT_ENABLE_N[*3] |-> PAR_OE_N == 8'h00) else $error("not driven");
  chk_oe_float: assert property (OUT_ENABLE_N[*3] |-> PAR_OE_N == 8'hff) else $error("not floated");
  // Storage quiet long enough means no load can still be in flight
  chk_par_hold: assert property (!STORAGE_CLOCK[*5] |=> $stable(PAR_OUT)) else $error("bad load");
  chk_serial_clr: assert property (!SHIFT_CLEAR_N |-> !SERIAL_OUT) else $error("clear");
  chk_serial_why: assert property ($changed(SERIAL_OUT) |-> $rose(SHIFT_CLOCK) || !SHIFT_CLEAR_N) else $error("cascade");
  chk_word_hold: assert property (WORD_VALID && !WORD_READY |=> WORD_VALID && $stable(WORD_DATA)) else $error("lost");
  chk_full_valid: assert property (!LOAD_READY |-> WORD_VALID) else $error("full");
  chk_push_load: assert property ($changed(PAR_OUT) |-> WORD_VALID) else $error("no push");
  cover property (!LOAD_READY);
  cover property (WORD_VALID && WORD_READY);
  cover property (!SHIFT_CLEAR_N && !SERIAL_OUT);
endmodule : sipo_latch_monitor
bind sipo_latch sipo_latch_monitor mon (.CLK_SYS, .RST, .SHIFT_CLOCK, .SERIAL_IN, .SHIFT_CLEAR_N, .STORAGE_CLOCK,
  .OUT_ENABLE_N, .PAR_OUT, .PAR_OE_N, .SERIAL_OUT, .LOAD_READY, .WORD_VALID, .WORD_READY, .WORD_DATA);

/* File: tb/sipo_latch_tb.sv */
// Bench for the latch: host model, stalled stream, clear, enable.
// Assumes the checker is bound to the design.
`timescale 1ns/10ps
module sipo_latch_tb;
  // --------
  // Setup
  // --------
  logic clk = 1'b0, rst = 1'b1, stc = 1'b0, oe_n = 1'b1, rdy = 1'b0, tie = 1'b0;
  wire logic sck, sin, clr_n;
  logic [7:0] par, oe, w, prev;
  logic [7:0] wq [3];
  logic sout, lrdy, vld;
  sipo_pkg::word_s wd;
  int err_total = 0, checked = 0;
  logic [31:0] seed = 32'h00000e02;
  always #2 clk = ~clk;
  host_link host (.SHIFT_CLOCK(sck), .SERIAL_IN(sin), .SHIFT_CLEAR_N(clr_n));
  sipo_latch dut (.CLK_SYS(clk), .RST(rst), .SHIFT_CLOCK(sck), .SERIAL_IN(sin), .SHIFT_CLEAR_N(clr_n),
    .STORAGE_CLOCK(tie ? sck : stc), .OUT_ENABLE_N(oe_n), .PAR_OUT(par), .PAR_OE_N(oe), .SERIAL_OUT(sout),
    .LOAD_READY(lrdy), .WORD_VALID(vld), .WORD_READY(rdy), .WORD_DATA(wd));
  function automatic logic [7:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : nxt
  // Tied clocks: storage sees contents from before the last edge
  function automatic logic [7:0] lag(input logic [7:0] s, input logic [7:0] v);
    return {s[0], v[7:1]};
  endfunction : lag
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // Pulse wide enough for the 2-flop sync, then let the load land
  task automatic store();
    @(negedge clk) stc = 1'b1;
    repeat (3) @(negedge clk);
    stc = 1'b0;
    repeat (6) @(negedge clk);
  endtask : store
  // --------
  // Scenarios
  // --------
  initial
  begin
    #100000 err_total++;
    end_sim();
  end
  initial
  begin
    repeat (5) @(negedge clk);
    chk(oe, 8'hff);
    rst = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      w = nxt();
      wq[i] = w;
      host.send(w);
      chk({7'h00, sout}, {7'h00, w[7]});
      store();
      chk(par, w);
    end
    chk({7'h00, lrdy}, 8'h00);
    chk(wd.bits, wq[0]);
    rdy = 1'b1;
    @(negedge clk) chk(wd.bits, wq[1]);
    @(negedge clk) rdy = 1'b0;
    chk({7'h00, vld}, 8'h00);
    prev = par;
    host.send(nxt());
    host.clear();
    chk({7'h00, sout}, 8'h00);
    chk(par, prev);
    store();
    chk(par, 8'h00);
    oe_n = 1'b0;
    repeat (3) @(negedge clk);
    chk(oe, 8'h00);
    oe_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(oe, 8'hff);
    chk(par, 8'h00);
    tie = 1'b1;
    w = nxt();
    host.send(w);
    repeat (6) @(negedge clk);
    chk(par, lag(8'h00, w));
    tie = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      w = nxt();
      rdy = w[0];
      host.send(w);
      store();
      chk(par, w);
    end
    end_sim();
  end
endmodule : sipo_latch_tb
